// >>> rtl/pll_fb_cfg_pkg.sv
package pll_fb_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets, as seen on the plain register port
  localparam logic [7:0] ADDR_PUMP_CTRL    = 8'h39;
  localparam logic [7:0] ADDR_FB_INT_HIGH  = 8'h3a;
  localparam logic [7:0] ADDR_FB_INT_LOW   = 8'h3b;
  localparam logic [7:0] ADDR_FRAC_NUM_HI  = 8'h3c;
  localparam logic [7:0] ADDR_FRAC_NUM_MID = 8'h3d;
  localparam logic [7:0] ADDR_FRAC_NUM_LO  = 8'h3e;
  localparam logic [7:0] ADDR_FRAC_DEN_HI  = 8'h3f;
  localparam logic [7:0] ADDR_FRAC_DEN_MID = 8'h40;
  localparam logic [7:0] ADDR_FRAC_DEN_LO  = 8'h41;
  localparam logic [7:0] ADDR_MOD_CTRL     = 8'h42;
  localparam logic [7:0] ADDR_LF_R2        = 8'h43;
  localparam int         REG_COUNT         = 11;
  localparam int         REG_IDX_W         = 4;

  // Register indices, offset minus the first offset
  localparam int IDX_PUMP_CTRL    = 0;
  localparam int IDX_FB_INT_HIGH  = 1;
  localparam int IDX_FB_INT_LOW   = 2;
  localparam int IDX_FRAC_NUM_HI  = 3;
  localparam int IDX_FRAC_NUM_MID = 4;
  localparam int IDX_FRAC_NUM_LO  = 5;
  localparam int IDX_FRAC_DEN_HI  = 6;
  localparam int IDX_FRAC_DEN_MID = 7;
  localparam int IDX_FRAC_DEN_LO  = 8;
  localparam int IDX_MOD_CTRL     = 9;
  localparam int IDX_LF_R2        = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PUMP_DBL_BIT   = 4;
  localparam int PUMP_RSV_BIT   = 5;
  localparam int MOD_ORDER_LSB  = 0;
  localparam int MOD_DITHER_LSB = 2;

  // Reset values, per register index
  localparam logic [7:0] REG_RST [REG_COUNT] = '{
    8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h24};

  // Implemented bits, per register index; the rest read zero
  localparam logic [7:0] REG_MASK [REG_COUNT] = '{
    8'h3f, 8'h0f, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h0f, 8'h3f};

  ////////////////////////////////////////////////////////////////////////////
  // Charge pump current, in units of 0.1 mA
  localparam logic [3:0] CP_CODE_MAX_STEP = 4'h7;
  localparam logic [3:0] CP_CODE_HIGH     = 4'h8;
  localparam logic [6:0] CP_STEP_100UA    = 7'h04;
  localparam logic [6:0] CP_HIGH_100UA    = 7'h40;

  // Modulator modes
  localparam logic [1:0] ORDER_INTEGER  = 2'h0;
  localparam logic [1:0] DITHER_DISABLE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Configuration seen by the analogue loop and the divider
  typedef struct packed {
    logic        primary_ref_doubler_en;
    logic [3:0]  charge_pump_gain_code;
    logic [11:0] feedback_int_divider;
    logic [21:0] frac_numerator;
    logic [21:0] frac_denominator;
    logic [1:0]  modulator_order_sel;
    logic [1:0]  modulator_dither_sel;
    logic [5:0]  loop_filter_resistor_code;
  } pll_cfg_t;

endpackage

// >>> rtl/fb_divider.sv
`timescale 1ns/1ps
module fb_divider
  import pll_fb_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  // Divider input and settings
  input  wire logic        fb_tick_in,
  input  wire logic [11:0] div_code_in,
  input  wire logic        frac_en_in,
  input  wire logic [21:0] num_in,
  input  wire logic [21:0] den_in,
  // Divided output
  output logic             fb_pulse_out
);

  logic [12:0] cnt_ff;
  logic        carry_ff;
  logic [22:0] acc_ff;
  logic        fb_pulse_ff;
  logic [11:0] eff_n;
  logic [12:0] target;
  logic [22:0] acc_sum;
  logic        carry;
  logic        wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Ratio for this output period; codes 0 and 1 both divide by one
  always_comb
  begin
    eff_n   = (div_code_in < 12'h002) ? 12'h001 : div_code_in;
    target  = {1'b0, eff_n} + {12'h000, carry_ff};
    acc_sum = acc_ff + {1'b0, num_in};
    carry   = frac_en_in && (den_in != 22'h000000) && (acc_sum >= {1'b0, den_in});
    wrap    = fb_tick_in && ((cnt_ff + 13'h0001) >= target);
  end

  // Tick counter, live compare so a new ratio acts at once
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      cnt_ff <= 13'h0000;
    else if (fb_tick_in)
      cnt_ff <= wrap ? 13'h0000 : cnt_ff + 13'h0001;
  end

  // First-order accumulator; numerator must stay below denominator
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      acc_ff   <= 23'h000000;
      carry_ff <= 1'b0;
    end
    else if (wrap)
    begin
      acc_ff   <= !frac_en_in ? 23'h000000 : carry ? acc_sum - {1'b0, den_in} : acc_sum;
      carry_ff <= carry;
    end
  end

  // Registered output pulse, one per divided period
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      fb_pulse_ff <= 1'b0;
    else
      fb_pulse_ff <= wrap;
  end

  assign fb_pulse_out = fb_pulse_ff;

  ////////////////////////////////////////////////////////////////////////////
  a_div_by_one: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    fb_tick_in && (div_code_in < 12'h002) && !frac_en_in && !carry_ff |=> fb_pulse_out)
    else $error("divide-by-one code missed a pulse");

  a_pulse_cause: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    fb_pulse_out |-> $past(fb_tick_in))
    else $error("feedback pulse without an input tick");

  // A ratio lowered below a count already reached is legal, so only a held ratio is checked
  a_cnt_bound: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !frac_en_in && !carry_ff && cnt_ff < {1'b0, eff_n} ##1 $stable(div_code_in)
    |-> cnt_ff < {1'b0, eff_n})
    else $error("integer count ran past the ratio");

endmodule

// >>> rtl/pll_feedback_divider_config.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

// How it works
// - The integer feedback ratio is one 12-bit value built from the two divider registers.
// - Ratio bits 11:8 sit in bits 3:0 of the upper divider register, reset zero, top bits read 0.
// - Ratio bits 7:0 fill the lower divider register, which resets to 0x66.
// - In integer mode codes 0 and 1 divide by one and every other code divides by exactly its value.
// - The 22-bit numerator spans three registers, bits 21:16 in the low six of the first.
// - The 22-bit denominator spans three registers in the same way, all reset to zero.
// - Modulator order is bits 1:0, reset 0, where 0 is integer and 1 to 3 pick the order.
// - Dither is bits 3:2, reset 3, where 0 weak, 1 medium, 2 strong and 3 off.
// - Bit 4 of the pump register enables the primary doubler and resets to one.
// - Pump gain bits 3:0 reset to 8; codes 1 to 7 give 0.4 mA steps and 8 gives 6.4 mA.
// - The six-bit loop filter R2 code resets to 0x24 and every code is accepted.
module pll_feedback_divider_config
  import pll_fb_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic  core_clk_in,
  input  wire logic  sys_rst_in,
  // Register port
  input  reg_req_t   req_in,
  output logic [7:0] rd_data_out,
  // Configuration to the loop
  output pll_cfg_t   cfg_out,
  output logic [6:0] cp_current_out,
  output logic       frac_mode_out,
  output logic       dither_on_out,
  // Feedback divider
  input  wire logic  fb_tick_in,
  output logic       fb_pulse_out
);

  logic [7:0]           regs_ff [REG_COUNT];
  logic [7:0]           rd_data_ff;
  logic [6:0]           cp_current_ff;
  logic [7:0]           rel_addr;
  logic [REG_IDX_W-1:0] idx;
  logic                 hit;
  logic [6:0]           nxt_cp_current;

  // Later checks share this clock and skip cycles in reset
  default clocking chk_clk @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; offsets outside the bank read zero and drop writes
  always_comb
  begin
    rel_addr = req_in.addr - ADDR_PUMP_CTRL;
    idx      = rel_addr[REG_IDX_W-1:0];
    hit      = (req_in.addr >= ADDR_PUMP_CTRL) && (req_in.addr <= ADDR_LF_R2);
  end

  // One storage entry per register, masked so reserved bits other than pump bit 5 stay zero
  for (genvar i = 0; i < REG_COUNT; i++)
  begin : g_reg
    always_ff @(posedge core_clk_in)
    begin
      if (sys_rst_in)
        regs_ff[i] <= REG_RST[i];
      else if (req_in.wr && hit && (idx == REG_IDX_W'(i)))
        regs_ff[i] <= req_in.wdata & REG_MASK[i];
    end
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      rd_data_ff <= 8'h00;
    else if (req_in.rd && hit)
      rd_data_ff <= regs_ff[idx];
    else
      rd_data_ff <= 8'h00;
  end

  assign rd_data_out = rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Field assembly; bytes are used as written, with no staging
  always_comb
  begin
    cfg_out.primary_ref_doubler_en    = regs_ff[IDX_PUMP_CTRL][PUMP_DBL_BIT];
    cfg_out.charge_pump_gain_code     = regs_ff[IDX_PUMP_CTRL][3:0];
    cfg_out.feedback_int_divider      = {regs_ff[IDX_FB_INT_HIGH][3:0],
                                         regs_ff[IDX_FB_INT_LOW]};
    cfg_out.frac_numerator            = {regs_ff[IDX_FRAC_NUM_HI][5:0],
                                         regs_ff[IDX_FRAC_NUM_MID],
                                         regs_ff[IDX_FRAC_NUM_LO]};
    cfg_out.frac_denominator          = {regs_ff[IDX_FRAC_DEN_HI][5:0],
                                         regs_ff[IDX_FRAC_DEN_MID],
                                         regs_ff[IDX_FRAC_DEN_LO]};
    cfg_out.modulator_order_sel       = regs_ff[IDX_MOD_CTRL][MOD_ORDER_LSB+:2];
    cfg_out.modulator_dither_sel      = regs_ff[IDX_MOD_CTRL][MOD_DITHER_LSB+:2];
    cfg_out.loop_filter_resistor_code = regs_ff[IDX_LF_R2][5:0];
  end

  // Mode flags for the modulator
  assign frac_mode_out = cfg_out.modulator_order_sel != ORDER_INTEGER;
  assign dither_on_out = cfg_out.modulator_dither_sel != DITHER_DISABLE;

  ////////////////////////////////////////////////////////////////////////////
  // Pump current decode; undefined codes give zero rather than a guess
  always_comb
  begin
    nxt_cp_current = 7'h00;
    if (cfg_out.charge_pump_gain_code == CP_CODE_HIGH)
      nxt_cp_current = CP_HIGH_100UA;
    else if (cfg_out.charge_pump_gain_code <= CP_CODE_MAX_STEP)
      nxt_cp_current = 7'(cfg_out.charge_pump_gain_code * CP_STEP_100UA);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      cp_current_ff <= CP_HIGH_100UA;
    else
      cp_current_ff <= nxt_cp_current;
  end

  assign cp_current_out = cp_current_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Feedback divider; only first-order carries are produced here
  fb_divider u_fb_divider (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .fb_tick_in   (fb_tick_in),
    .div_code_in  (cfg_out.feedback_int_divider),
    .frac_en_in   (frac_mode_out),
    .num_in       (cfg_out.frac_numerator),
    .den_in       (cfg_out.frac_denominator),
    .fb_pulse_out (fb_pulse_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_rst_divider: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> cfg_out.feedback_int_divider == 12'h066)
    else $error("divider reset value wrong");

  a_rst_modes: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> cfg_out.modulator_dither_sel == 2'h3
      && cfg_out.modulator_order_sel == 2'h0 && !dither_on_out && !frac_mode_out)
    else $error("modulator reset value wrong");

  a_rst_pump: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> cfg_out.primary_ref_doubler_en
      && cfg_out.charge_pump_gain_code == 4'h8 && cfg_out.loop_filter_resistor_code == 6'h24)
    else $error("pump or filter reset value wrong");

  a_rst_frac: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(sys_rst_in) |-> cfg_out.frac_numerator == 22'h000000
      && cfg_out.frac_denominator == 22'h000000)
    else $error("fraction reset value wrong");

  a_div_high_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_FB_INT_HIGH
    |=> cfg_out.feedback_int_divider[11:8] == $past(req_in.wdata[3:0]))
    else $error("upper divider bits not taken");

  a_div_low_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_FB_INT_LOW
    |=> cfg_out.feedback_int_divider[7:0] == $past(req_in.wdata))
    else $error("lower divider bits not taken");

  a_num_high_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_FRAC_NUM_HI
    |=> cfg_out.frac_numerator[21:16] == $past(req_in.wdata[5:0]))
    else $error("numerator top bits not taken");

  a_den_mid_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_FRAC_DEN_MID
    |=> cfg_out.frac_denominator[15:8] == $past(req_in.wdata))
    else $error("denominator middle byte not taken");

  a_mod_ctrl_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_MOD_CTRL
    |=> cfg_out.modulator_order_sel == $past(req_in.wdata[1:0])
      && cfg_out.modulator_dither_sel == $past(req_in.wdata[3:2]))
    else $error("modulator control not taken");

  a_doubler_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_PUMP_CTRL
    |=> cfg_out.primary_ref_doubler_en == $past(req_in.wdata[4]))
    else $error("doubler enable not taken");

  a_cp_current: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cfg_out.charge_pump_gain_code == 4'h3 ##1 1'b1 |-> cp_current_out == 7'h0c)
    else $error("pump current decode wrong");

  a_r2_wr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_LF_R2
    |=> cfg_out.loop_filter_resistor_code == $past(req_in.wdata[5:0]))
    else $error("R2 code not taken");

  a_rsv_readback: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    req_in.wr && req_in.addr == ADDR_PUMP_CTRL ##1 req_in.rd && req_in.addr == ADDR_PUMP_CTRL
    |=> rd_data_out == ($past(req_in.wdata, 2) & 8'h3f))
    else $error("pump register readback wrong");

  a_read_idle: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !req_in.rd |=> rd_data_out == 8'h00)
    else $error("read data outside the answer cycle");

  // Write paths for the bytes not covered above
  a_num_mid_wr: assert property (
    req_in.wr && req_in.addr == ADDR_FRAC_NUM_MID
    |=> cfg_out.frac_numerator[15:8] == $past(req_in.wdata))
    else $error("numerator middle byte not taken");

  a_num_low_wr: assert property (
    req_in.wr && req_in.addr == ADDR_FRAC_NUM_LO
    |=> cfg_out.frac_numerator[7:0] == $past(req_in.wdata))
    else $error("numerator low byte not taken");

  a_den_high_wr: assert property (
    req_in.wr && req_in.addr == ADDR_FRAC_DEN_HI
    |=> cfg_out.frac_denominator[21:16] == $past(req_in.wdata[5:0]))
    else $error("denominator top bits not taken");

  a_den_low_wr: assert property (
    req_in.wr && req_in.addr == ADDR_FRAC_DEN_LO
    |=> cfg_out.frac_denominator[7:0] == $past(req_in.wdata))
    else $error("denominator low byte not taken");

  a_pump_gain_wr: assert property (
    req_in.wr && req_in.addr == ADDR_PUMP_CTRL
    |=> cfg_out.charge_pump_gain_code == $past(req_in.wdata[3:0]))
    else $error("pump gain code not taken");

  // Readback shows what the loop sees, with reserved bits other than pump bit 5 at zero
  a_rd_div_high: assert property (
    req_in.rd && req_in.addr == ADDR_FB_INT_HIGH
    |=> rd_data_out == {4'h0, $past(cfg_out.feedback_int_divider[11:8])})
    else $error("upper divider readback wrong");

  a_rd_div_low: assert property (
    req_in.rd && req_in.addr == ADDR_FB_INT_LOW
    |=> rd_data_out == $past(cfg_out.feedback_int_divider[7:0]))
    else $error("lower divider readback wrong");

  a_rd_num_high: assert property (
    req_in.rd && req_in.addr == ADDR_FRAC_NUM_HI
    |=> rd_data_out == {2'h0, $past(cfg_out.frac_numerator[21:16])})
    else $error("numerator top readback wrong");

  a_rd_num_mid: assert property (
    req_in.rd && req_in.addr == ADDR_FRAC_NUM_MID
    |=> rd_data_out == $past(cfg_out.frac_numerator[15:8]))
    else $error("numerator middle readback wrong");

  a_rd_den_high: assert property (
    req_in.rd && req_in.addr == ADDR_FRAC_DEN_HI
    |=> rd_data_out == {2'h0, $past(cfg_out.frac_denominator[21:16])})
    else $error("denominator top readback wrong");

  a_rd_den_low: assert property (
    req_in.rd && req_in.addr == ADDR_FRAC_DEN_LO
    |=> rd_data_out == $past(cfg_out.frac_denominator[7:0]))
    else $error("denominator low readback wrong");

  a_rd_mod: assert property (
    req_in.rd && req_in.addr == ADDR_MOD_CTRL
    |=> rd_data_out == {4'h0, $past(cfg_out.modulator_dither_sel),
                        $past(cfg_out.modulator_order_sel)})
    else $error("modulator readback wrong");

  a_rd_pump: assert property (
    req_in.rd && req_in.addr == ADDR_PUMP_CTRL
    |=> rd_data_out[7:6] == 2'h0 && rd_data_out[4:0]
      == $past({cfg_out.primary_ref_doubler_en, cfg_out.charge_pump_gain_code}))
    else $error("pump readback wrong");

  a_rd_r2: assert property (
    req_in.rd && req_in.addr == ADDR_LF_R2
    |=> rd_data_out == {2'h0, $past(cfg_out.loop_filter_resistor_code)})
    else $error("R2 readback wrong");

  a_rd_mask: assert property (
    req_in.rd && hit
    |=> (rd_data_out & ~REG_MASK[$past(idx)]) == 8'h00)
    else $error("reserved bits read nonzero");

  a_rd_miss: assert property (
    req_in.rd && !hit
    |=> rd_data_out == 8'h00)
    else $error("unmapped read returned data");

  a_wr_miss: assert property (
    req_in.wr && !hit
    |=> $stable(cfg_out))
    else $error("unmapped write changed the bank");

  // Pump current decode at its end points
  a_rst_cp: assert property (
    $past(sys_rst_in)
    |-> cp_current_out == CP_HIGH_100UA)
    else $error("pump current reset value wrong");

  a_cp_high: assert property (
    cfg_out.charge_pump_gain_code == CP_CODE_HIGH ##1 1'b1
    |-> cp_current_out == CP_HIGH_100UA)
    else $error("high pump code decode wrong");

  a_cp_undef: assert property (
    (cfg_out.charge_pump_gain_code == 4'h0
      || cfg_out.charge_pump_gain_code > CP_CODE_HIGH) ##1 1'b1
    |-> cp_current_out == 7'h00)
    else $error("undefined pump code gave current");

endmodule

// >>> testbench/test_pll_feedback_divider_config.sv
`timescale 1ns/1ps
module test_pll_feedback_divider_config
  import pll_fb_cfg_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // Design ports and bench state
  logic       core_clk_in;
  logic       sys_rst_in;
  reg_req_t   req;
  logic [7:0] rd_data_out;
  pll_cfg_t   cfg_out;
  logic [6:0] cp_current_out;
  logic       frac_mode_out;
  logic       dither_on_out;
  logic       fb_tick_in;
  logic       fb_pulse_out;
  logic [7:0] mdl [REG_COUNT];
  integer     seed;
  int         fail_count;
  int         n_tests;
  localparam logic [7:0] LF_CODES [6] = '{8'hc1, 8'hc2, 8'hc4, 8'hc8, 8'he0, 8'hf0};

  pll_feedback_divider_config u_dut (
    .core_clk_in    (core_clk_in),
    .sys_rst_in     (sys_rst_in),
    .req_in         (req),
    .rd_data_out    (rd_data_out),
    .cfg_out        (cfg_out),
    .cp_current_out (cp_current_out),
    .frac_mode_out  (frac_mode_out),
    .dither_on_out  (dither_on_out),
    .fb_tick_in     (fb_tick_in),
    .fb_pulse_out   (fb_pulse_out)
  );

  // Free running core clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [6:0] cp_exp(input logic [3:0] c);
    if (c == 4'h8) return 7'h40;
    if (c >= 4'h1 && c <= 4'h7) return {3'h0, c} * 7'h04;
    return 7'h00; // Undefined codes give no current
  endfunction

  function automatic logic [31:0] eff_div(input logic [11:0] n);
    return (n < 12'h002) ? 32'h1 : {20'h0, n};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port master; model keeps only implemented bits
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req.wr <= 1'b0;
    if (addr >= ADDR_PUMP_CTRL && addr <= ADDR_LF_R2)
      mdl[addr - ADDR_PUMP_CTRL] = data & REG_MASK[addr - ADDR_PUMP_CTRL];
  endtask

  task automatic rd_check(input logic [7:0] addr);
    logic [7:0] e;
    e = 8'h00;
    if (addr >= ADDR_PUMP_CTRL && addr <= ADDR_LF_R2) e = mdl[addr - ADDR_PUMP_CTRL];
    @(posedge core_clk_in);
    req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    #1;
    check({24'h0, rd_data_out}, {24'h0, e});
  endtask

  // Write then read the same offset on the very next strobe, no idle cycle
  task automatic wr_rd_check(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] e;
    e = 8'h00;
    if (addr >= ADDR_PUMP_CTRL && addr <= ADDR_LF_R2)
    begin
      e = data & REG_MASK[addr - ADDR_PUMP_CTRL];
      mdl[addr - ADDR_PUMP_CTRL] = e;
    end
    @(posedge core_clk_in);
    req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    #1;
    check({24'h0, rd_data_out}, {24'h0, e});
  endtask

  task automatic read_all();
    for (int i = 0; i < REG_COUNT; i++) rd_check(ADDR_PUMP_CTRL + 8'(i));
  endtask

  // Fields of the loop configuration against the model
  task automatic check_cfg();
    @(posedge core_clk_in);
    #1;
    check(cfg_out.feedback_int_divider, {mdl[1][3:0], mdl[2]});
    check(cfg_out.frac_numerator, {mdl[3][5:0], mdl[4], mdl[5]});
    check(cfg_out.frac_denominator, {mdl[6][5:0], mdl[7], mdl[8]});
    check(cfg_out.modulator_order_sel, mdl[9][1:0]);
    check(frac_mode_out, mdl[9][1:0] != 2'h0);
    check(cfg_out.modulator_dither_sel, mdl[9][3:2]);
    check(dither_on_out, mdl[9][3:2] != 2'h3);
    check(cfg_out.primary_ref_doubler_en, mdl[0][4]);
    check(cfg_out.charge_pump_gain_code, mdl[0][3:0]);
    check(cp_current_out, cp_exp(mdl[0][3:0]));
    check(cfg_out.loop_filter_resistor_code, mdl[10][5:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Divider run: random tick spacing, period counted in ticks taken
  task automatic div_run(input logic [11:0] n, input logic [1:0] order,
                         input logic [21:0] num, input logic [21:0] den);
    logic [31:0] per [4];
    logic [31:0] cnt;
    logic        prev;
    int          np;
    int          guard;
    reg_wr(ADDR_FB_INT_HIGH, {4'h0, n[11:8]});
    reg_wr(ADDR_FB_INT_LOW, n[7:0]);
    reg_wr(ADDR_FRAC_NUM_HI, {2'h0, num[21:16]});
    reg_wr(ADDR_FRAC_NUM_MID, num[15:8]);
    reg_wr(ADDR_FRAC_NUM_LO, num[7:0]);
    reg_wr(ADDR_FRAC_DEN_HI, {2'h0, den[21:16]});
    reg_wr(ADDR_FRAC_DEN_MID, den[15:8]);
    reg_wr(ADDR_FRAC_DEN_LO, den[7:0]);
    reg_wr(ADDR_MOD_CTRL, {4'h0, DITHER_DISABLE, order});
    cnt = 32'h0;
    np = 0;
    guard = 0;
    while (np < 4 && guard < 40000)
    begin
      @(posedge core_clk_in);
      prev = fb_tick_in;
      fb_tick_in <= ($random(seed) & 3) != 0;
      #1;
      cnt = cnt + {31'h0, prev};
      guard++;
      if (fb_pulse_out === 1'b1)
      begin
        per[np] = cnt;
        np++;
        cnt = 32'h0;
      end
    end
    @(posedge core_clk_in);
    fb_tick_in <= 1'b0;
    check(np, 4);
    // First period is skipped: the count it started from is unknown
    if (order == ORDER_INTEGER)
    begin
      check(per[1], eff_div(n));
      check(per[2], eff_div(n));
    end
    else check(per[1] + per[2], 2 * eff_div(n) + 1);
    $display("test divider n=%0d order=%0d done", n, order);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 32'h1db3;
    fail_count = 0;
    n_tests = 0;
    req = '0;
    fb_tick_in = 1'b0;
    sys_rst_in = 1'b1;
    for (int i = 0; i < REG_COUNT; i++) mdl[i] = REG_RST[i];
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    check_cfg();
    read_all();
    $display("test reset_values done");
    // Random writes, each read back in the very next request
    repeat (24)
    begin
      automatic logic [7:0] a = ADDR_PUMP_CTRL + 8'($unsigned($random(seed)) % REG_COUNT);
      wr_rd_check(a, 8'($random(seed)));
    end
    wr_rd_check(ADDR_PUMP_CTRL, 8'hff);
    check_cfg();
    check(rd_data_out, 8'h00);
    $display("test random_regs done");
    // Unmapped offsets neither store nor disturb the bank
    reg_wr(8'h44, 8'hff);
    reg_wr(8'h38, 8'hff);
    rd_check(8'h44);
    rd_check(8'h38);
    read_all();
    $display("test unmapped done");
    // Every order and dither code, reserved bits set
    for (int o = 0; o < 4; o++)
      for (int d = 0; d < 4; d++)
      begin
        reg_wr(ADDR_MOD_CTRL, {4'hf, 2'(d), 2'(o)});
        check_cfg();
      end
    $display("test modulator_modes done");
    // Every pump code, with random doubler and reserved bits
    for (int c = 0; c < 16; c++)
    begin
      reg_wr(ADDR_PUMP_CTRL, {4'($random(seed)), 4'(c)});
      check_cfg();
    end
    read_all();
    $display("test pump_codes done");
    for (int i = 0; i < 6; i++)
    begin
      reg_wr(ADDR_LF_R2, LF_CODES[i]);
      check_cfg();
    end
    $display("test filter_codes done");
    div_run(12'h000, ORDER_INTEGER, 22'h0, 22'h0);
    div_run(12'h001, ORDER_INTEGER, 22'h0, 22'h0);
    div_run(12'h002, ORDER_INTEGER, 22'h0, 22'h0);
    div_run(12'h003 + 12'($unsigned($random(seed)) % 38), ORDER_INTEGER, 22'h0, 22'h0);
    div_run(12'hfff, ORDER_INTEGER, 22'h0, 22'h0);
    div_run(12'h007, 2'h1, 22'h1, 22'h2);
    print_verdict();
  end

  // Watchdog, well beyond the longest divider run
  initial
  begin
    #3600000;
    fail_count++;
    print_verdict();
  end
endmodule
